// file: core/ccr_channel.sv
// One capture/compare channel: preload holder, active compare value and capture.
// Assumes a synchronous single-cycle write strobe and one-cycle event pulses.
`timescale 1ns/10ps
`include "timer_ccr_regs.svh"

module ccr_channel
  import timer_ccr_pkg::*;
(
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_i,
  // Register side.
  input wire logic wr_i,
  input wire logic [31:0] wdata_i,
  input wire logic preload_en_i,
  input wire cc_dir_t dir_i,
  input wire logic cap_en_i,
  input wire logic [31:0] width_mask_i,
  // Timer side.
  input wire logic cap_evt_i,
  input wire logic update_i,
  input wire logic [31:0] counter_i,
  // Results.
  output logic [31:0] value_o,
  output logic match_o
);

  logic [31:0] shadow_r;
  logic [31:0] active_r;
  logic match_r;
  logic [31:0] shadow_nxt;
  logic [31:0] active_nxt;
  logic match_nxt;
  logic is_output;
  logic cap_take;
  logic [31:0] counter_m;

  // A capture beats a software write in the same cycle, so no counter sample is lost.
  assign is_output = (dir_i == CC_DIR_OUTPUT);
  assign counter_m = counter_i & width_mask_i;
  assign cap_take = !is_output && cap_en_i && cap_evt_i;
  assign shadow_nxt = cap_take ? counter_m :
                      wr_i ? (wdata_i & width_mask_i) : shadow_r;
  // In output mode, without preload the active value tracks the holder; with it, only an update copies.
  assign active_nxt = !is_output ? active_r :
                      !preload_en_i ? shadow_nxt :
                      update_i ? shadow_r : active_r;
  assign match_nxt = is_output && (counter_m == active_r);

  // State of the channel.
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      shadow_r <= `VALUE_RESET;
      active_r <= `VALUE_RESET;
      match_r <= 1'b0;
    end
    else
    begin
      shadow_r <= shadow_nxt;
      active_r <= active_nxt;
      match_r <= match_nxt;
    end
  end

  assign value_o = shadow_r;
  assign match_o = match_r;

endmodule // ccr_channel

// file: core/timer_ccr_dma_burst.sv
// Capture/compare value registers, burst access window and trigger remap of a timer.
// Assumes the counter, update event and capture pulses come from the timer core and
// that the timer's other registers answer a forwarded read in the same cycle.
// Also assumes the bus master never raises both strobes in one cycle.
`timescale 1ns/10ps
`include "timer_ccr_regs.svh"

module timer_ccr_dma_burst
  import timer_ccr_pkg::*;
#(
  parameter bit WIDE_TIMER = 1'b1
)
(
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_i,
  // Register port.
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Forwarded burst accesses to the timer's other registers.
  output logic [7:0] fwd_addr_o,
  output logic [15:0] fwd_wdata_o,
  output logic fwd_wr_o,
  output logic fwd_rd_o,
  input wire logic [15:0] fwd_rdata_i,
  // Timer core.
  input wire logic [31:0] running_counter_i,
  input wire logic update_evt_i,
  input wire logic [3:0] capture_evt_i,
  input wire logic trc_evt_i,
  output logic [3:0] compare_output_o,
  output logic [4:0] burst_index_o,
  // Trigger sources.
  input wire logic other_timer_trigger_out_i,
  input wire logic ptp_trigger_i,
  input wire logic usb_fs_sof_i,
  input wire logic usb_hs_sof_i,
  output logic internal_trigger_one_o
);

  // ************************************************************
  // Declarations.
  // ************************************************************
  logic [4:0] burst_length_r;
  logic [4:0] burst_base_offset_r;
  logic [4:0] burst_index_r;
  logic [4:0] burst_index_nxt;
  trig_remap_t trigger_one_remap_r;
  logic [15:0] chan_cfg_r;
  logic [15:0] chan_cfg_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic trig_r;
  logic trig_nxt;
  logic [31:0] width_mask;
  logic win_hit;
  logic win_access;
  logic [5:0] eff_index;
  logic [7:0] eff_addr;
  logic [7:0] acc_addr;
  logic [31:0] acc_wdata;
  logic acc_wr;
  logic acc_rd;
  logic acc_live;
  logic fwd_hit;
  logic dcr_wr;
  logic opt_wr;
  logic cfg_wr;
  logic [3:0] ch_wr;
  logic [3:0] ch_hit;
  logic [3:0] ch_match;
  logic [31:0] ch_value [4];
  logic [31:0] ch_rd_value;
  logic [31:0] local_rd_value;
  logic [15:0] burst_ctrl_view;

  // Narrow instances keep only the low half of every value.
  // The mask is applied on the way in, so a narrow instance never holds stray upper bits.
  assign width_mask = WIDE_TIMER ? `WIDE_MASK : `NARROW_MASK;

  // ************************************************************
  // Burst window redirection.
  // ************************************************************

  // The window has no storage; every hit except one aimed at the window itself is turned into an access elsewhere.
  // Base and index count registers, so each step moves the target on by four bytes.
  // A burst that runs past the last register simply lands on unmapped, silent space.
  assign win_hit = (addr_i == `BURST_WINDOW_OFS);
  assign win_access = win_hit && (wr_i || rd_i);
  assign eff_index = {1'b0, burst_base_offset_r} + {1'b0, burst_index_r};
  assign eff_addr = `CTRL_ONE_OFS + {eff_index, 2'b00};

  // Effective access after redirection; a window pointing at itself does nothing.
  // Such a self-pointing access still moves the index, so the burst keeps its count.
  assign acc_addr = win_hit ? eff_addr : addr_i;
  assign acc_wdata = win_hit ? {16'h0000, wdata_i[15:0]} : wdata_i;
  assign acc_live = !(win_hit && (eff_addr == `BURST_WINDOW_OFS));
  assign acc_wr = wr_i && acc_live;
  assign acc_rd = rd_i && acc_live;

  // Only burst traffic reaches the other timer registers through this block.
  assign fwd_hit = win_hit && (eff_addr <= `FWD_LAST_OFS);
  assign fwd_addr_o = eff_addr;
  assign fwd_wdata_o = wdata_i[15:0];
  assign fwd_wr_o = fwd_hit && wr_i;
  assign fwd_rd_o = fwd_hit && rd_i;

  // ************************************************************
  // Local register decode.
  // ************************************************************
  // Redirected accesses decode exactly like direct ones, so a burst may even rewrite the
  // burst control itself; that write then restarts the index as any other would.
  assign dcr_wr = acc_wr && (acc_addr == `BURST_CTRL_OFS);
  assign opt_wr = acc_wr && (acc_addr == `TRIG_OPTION_OFS);
  assign cfg_wr = acc_wr && (acc_addr == `CHAN_CFG_OFS);

  // ************************************************************
  // Burst index.
  // ************************************************************

  // The index wraps after the last transfer so the next burst restarts at the base.
  // Rewriting the burst control also restarts the burst, which avoids a stale index.
  // Length codes above the eighteen-transfer one are not refused; the index runs longer.
  assign burst_index_nxt = dcr_wr ? 5'h00 :
                           !win_access ? burst_index_r :
                           (burst_index_r == burst_length_r) ? 5'h00 :
                           burst_index_r + 5'h01;

  // ************************************************************
  // Control registers.
  // ************************************************************

  // Burst control, trigger remap and the index.
  // The remap field is changed by software only; nothing in the timer writes it.
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      burst_length_r <= `BURST_FIELD_RESET;
      burst_base_offset_r <= `BURST_FIELD_RESET;
      burst_index_r <= `BURST_FIELD_RESET;
      trigger_one_remap_r <= trig_remap_t'(`TRIG_REMAP_RESET);
    end
    else
    begin
      if (dcr_wr)
      begin
        burst_length_r <= acc_wdata[`BURST_LEN_MSB:`BURST_LEN_LSB];
        burst_base_offset_r <= acc_wdata[`BURST_BASE_MSB:`BURST_BASE_LSB];
      end
      if (opt_wr)
      begin
        trigger_one_remap_r <= trig_remap_t'(acc_wdata[`TRIG_REMAP_MSB:`TRIG_REMAP_LSB]);
      end
      burst_index_r <= burst_index_nxt;
    end
  end

  // Channel configuration; a direction may change only while capture is disabled.
  // The guard uses the enable as it stands before the write, so one write that clears the
  // enable cannot also move the direction; software needs two writes for that.
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      chan_cfg_r <= `CHAN_CFG_RESET;
    end
    else
    begin
      chan_cfg_r <= chan_cfg_nxt;
    end
  end

  // ************************************************************
  // Channels.
  // ************************************************************
  // Each slice owns one nibble of the configuration register. The neighbour of a channel
  // is its pair partner, so channels one and two feed each other, as do three and four.
  genvar n;
  generate
    for (n = 0; n < 4; n++)
    begin : g_ch
      localparam int NB = n ^ 1;
      localparam int B = n * `CFG_FIELD_W;
      cc_dir_t dir;
      logic cap_src;
      logic [31:0] cfg_w;

      assign cfg_w = acc_wdata;
      // Field update; the direction is held while the capture enable is set.
      assign chan_cfg_nxt[B + `CFG_DIR_LSB +: 2] =
        (cfg_wr && !chan_cfg_r[B + `CFG_CAPEN_BIT]) ?
        cfg_w[B + `CFG_DIR_LSB +: 2] : chan_cfg_r[B + `CFG_DIR_LSB +: 2];
      assign chan_cfg_nxt[B + `CFG_PRELOAD_BIT] =
        cfg_wr ? cfg_w[B + `CFG_PRELOAD_BIT] : chan_cfg_r[B + `CFG_PRELOAD_BIT];
      assign chan_cfg_nxt[B + `CFG_CAPEN_BIT] =
        cfg_wr ? cfg_w[B + `CFG_CAPEN_BIT] : chan_cfg_r[B + `CFG_CAPEN_BIT];

      // Capture source follows the direction code.
      assign dir = cc_dir_t'(chan_cfg_r[B + `CFG_DIR_LSB +: 2]);
      assign cap_src = (dir == CC_DIR_OWN) ? capture_evt_i[n] :
                       (dir == CC_DIR_NEIGHBOUR) ? capture_evt_i[NB] :
                       (dir == CC_DIR_TRIGGER) ? trc_evt_i : 1'b0;

      assign ch_hit[n] = (acc_addr == (`CH1_VALUE_OFS + 8'(4 * n)));
      assign ch_wr[n] = acc_wr && ch_hit[n];

      ccr_channel u_channel (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .wr_i(ch_wr[n]),
        .wdata_i(acc_wdata),
        .preload_en_i(chan_cfg_r[B + `CFG_PRELOAD_BIT]),
        .dir_i(dir),
        .cap_en_i(chan_cfg_r[B + `CFG_CAPEN_BIT]),
        .width_mask_i(width_mask),
        .cap_evt_i(cap_src),
        .update_i(update_evt_i),
        .counter_i(running_counter_i),
        .value_o(ch_value[n]),
        .match_o(ch_match[n])
      );
    end
  endgenerate

  assign compare_output_o = ch_match;

  // ************************************************************
  // Internal trigger one.
  // ************************************************************

  // Registered so the trigger line does not glitch when software changes the source.
  // The four source lines are taken as already synchronous to the register clock.
  assign trig_nxt = (trigger_one_remap_r == REMAP_OTHER_TIMER) ? other_timer_trigger_out_i :
                    (trigger_one_remap_r == REMAP_PRECISION_TIME) ? ptp_trigger_i :
                    (trigger_one_remap_r == REMAP_USB_FS_SOF) ? usb_fs_sof_i :
                    usb_hs_sof_i;

  // ************************************************************
  // Read path.
  // ************************************************************

  // Reserved fields of the burst control are built as zeros.
  assign burst_ctrl_view = {3'b000, burst_length_r, 3'b000, burst_base_offset_r};

  assign ch_rd_value = ch_hit[0] ? ch_value[0] :
                       ch_hit[1] ? ch_value[1] :
                       ch_hit[2] ? ch_value[2] :
                       ch_hit[3] ? ch_value[3] : 32'h0000_0000;

  // Unmapped addresses read as zero; window reads see only the low half of the target.
  assign local_rd_value =
    (|ch_hit) ? ch_rd_value :
    (acc_addr == `BURST_CTRL_OFS) ? {16'h0000, burst_ctrl_view} :
    (acc_addr == `TRIG_OPTION_OFS) ? {20'h00000, trigger_one_remap_r, 10'h000} :
    (acc_addr == `CHAN_CFG_OFS) ? {16'h0000, chan_cfg_r} : 32'h0000_0000;

  // Window reads keep only the low half, since a burst moves sixteen bits per transfer.
  // The data is zero outside a read answer, so slaves whose data are ORed stay clean.
  assign rdata_nxt = !acc_rd ? 32'h0000_0000 :
                     fwd_hit ? {16'h0000, fwd_rdata_i} :
                     win_hit ? {16'h0000, local_rd_value[15:0]} : local_rd_value;

  // Read data and trigger flops.
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      rdata_r <= 32'h0000_0000;
      trig_r <= 1'b0;
    end
    else
    begin
      rdata_r <= rdata_nxt;
      trig_r <= trig_nxt;
    end
  end

  // Read data, trigger and index outputs come straight from flops, so no decode glitch reaches those pins.
  assign rdata_o = rdata_r;
  assign internal_trigger_one_o = trig_r;
  assign burst_index_o = burst_index_r;

endmodule // timer_ccr_dma_burst

// file: core/timer_ccr_pkg.sv
// Types shared by the capture/compare block and its channel slice.
// Assumes the register header is compiled alongside.
package timer_ccr_pkg;

  // Channel direction select codes.
  typedef enum logic [1:0] {
    CC_DIR_OUTPUT = 2'b00,
    CC_DIR_OWN = 2'b01,
    CC_DIR_NEIGHBOUR = 2'b10,
    CC_DIR_TRIGGER = 2'b11
  } cc_dir_t;

  // Sources for internal trigger one.
  typedef enum logic [1:0] {
    REMAP_OTHER_TIMER = 2'b00,
    REMAP_PRECISION_TIME = 2'b01,
    REMAP_USB_FS_SOF = 2'b10,
    REMAP_USB_HS_SOF = 2'b11
  } trig_remap_t;

endpackage

// file: core/timer_ccr_regs.svh
// Register offsets, field positions, reset values and masks of the capture/compare block.
// Assumes byte addresses on an 8-bit register address and 32-bit data words.
`ifndef TIMER_CCR_REGS_SVH
`define TIMER_CCR_REGS_SVH

// ************************************************************
// Register byte offsets.
// ************************************************************
`define CTRL_ONE_OFS 8'h00
`define FWD_LAST_OFS 8'h30
`define CH1_VALUE_OFS 8'h34
`define CH2_VALUE_OFS 8'h38
`define CH3_VALUE_OFS 8'h3C
`define CH4_VALUE_OFS 8'h40
`define BURST_CTRL_OFS 8'h48
`define BURST_WINDOW_OFS 8'h4C
`define TRIG_OPTION_OFS 8'h50
`define CHAN_CFG_OFS 8'h54

// ************************************************************
// Field positions.
// ************************************************************
`define BURST_LEN_MSB 12
`define BURST_LEN_LSB 8
`define BURST_BASE_MSB 4
`define BURST_BASE_LSB 0
`define TRIG_REMAP_MSB 11
`define TRIG_REMAP_LSB 10
`define CFG_FIELD_W 4
`define CFG_DIR_LSB 0
`define CFG_PRELOAD_BIT 2
`define CFG_CAPEN_BIT 3

// ************************************************************
// Reset values and value masks.
// ************************************************************
`define VALUE_RESET 32'h0000_0000
`define BURST_FIELD_RESET 5'h00
`define TRIG_REMAP_RESET 2'h0
`define CHAN_CFG_RESET 16'h0000
`define WIDE_MASK 32'hFFFF_FFFF
`define NARROW_MASK 32'h0000_FFFF

`endif

// file: dv/timer_ccr_dma_burst_bench.sv
// Self-checking bench of the capture/compare register block.
// Assumes the checker binds itself and the register model answers forwarded accesses.
`timescale 1ns/10ps
module timer_ccr_dma_burst_bench;
  // ************************************************************
  // Stimulus, bus tasks and result checking.
  // ************************************************************
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, running_counter_i = 32'h0, rdata_o;
  logic wr_i = 1'b0, rd_i = 1'b0, update_evt_i = 1'b0, trc_evt_i = 1'b0, rd_seen = 1'b0;
  logic [3:0] capture_evt_i = 4'h0, src = 4'h0, compare_output_o;
  logic [7:0] fwd_addr_o;
  logic [15:0] fwd_wdata_o, fwd_rdata_i;
  logic fwd_wr_o, fwd_rd_o, internal_trigger_one_o;
  logic [4:0] burst_index_o;
  logic [31:0] seed = 32'h5BA1, w, c, r, d0, d1;
  logic [31:0] v [4];
  logic [31:0] exp_q [$];
  int mismatches = 0, check_count = 0, cycles = 0;

  always #20 mclk_i = ~mclk_i;

  timer_ccr_dma_burst u_dut (.mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .fwd_addr_o, .fwd_wdata_o, .fwd_wr_o, .fwd_rd_o, .fwd_rdata_i, .running_counter_i,
    .update_evt_i, .capture_evt_i, .trc_evt_i, .compare_output_o, .burst_index_o,
    .other_timer_trigger_out_i(src[0]), .ptp_trigger_i(src[1]), .usb_fs_sof_i(src[2]),
    .usb_hs_sof_i(src[3]), .internal_trigger_one_o);
  timer_regs_model u_regs (.mclk_i, .rst_i, .fwd_addr_o, .fwd_wdata_o, .fwd_wr_o,
    .fwd_rd_o, .fwd_rdata_i);

  function logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  task complete_run;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Compare outputs of all four channels at once.
  task chk_compare(input logic [3:0] got, input logic [3:0] exp);
    chk({28'h0, got}, {28'h0, exp});
  endtask

  // Internal trigger one.
  task chk_trigger(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  // The expected answer is noted before the strobe goes out.
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk_i);
    exp_q.push_back(e);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
  endtask

  task pulse(input logic [3:0] ev, input logic trc, input logic upd);
    @(posedge mclk_i);
    capture_evt_i <= ev;
    trc_evt_i <= trc;
    update_evt_i <= upd;
    @(posedge mclk_i);
    capture_evt_i <= 4'h0;
    trc_evt_i <= 1'b0;
    update_evt_i <= 1'b0;
  endtask

  task settle;
    repeat (2) @(posedge mclk_i);
    #1;
  endtask

  // Read data stands only in the cycle after the strobe, so it is taken there.
  always @(posedge mclk_i)
  begin
    if (rd_seen)
      chk(rdata_o, exp_q.pop_front());
    rd_seen <= rd_i;
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      complete_run;
    end
  end

  initial
  begin
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    for (int a = 'h34; a <= 'h50; a += 4) rd(8'(a), 32'h0);
    rd(8'h60, 32'h0);
    rd(8'h10, 32'h0);
    for (int n = 0; n < 4; n++)
    begin
      v[n] = rnd();
      wr(8'h34 + 8'(4 * n), v[n]);
      running_counter_i <= v[n];
      settle;
      chk_compare(compare_output_o, 4'(1 << n));
      rd(8'h34 + 8'(4 * n), v[n]);
    end
    wr(8'h54, 32'h40);
    w = rnd();
    wr(8'h38, w);
    running_counter_i <= w;
    settle;
    chk_compare(compare_output_o, 4'h0);
    pulse(4'h0, 1'b0, 1'b1);
    settle;
    chk_compare(compare_output_o, 4'h2);
    for (int k = 1; k < 4; k++)
    begin
      wr(8'h54, 32'h1040);
      wr(8'h54, 32'h1840 | 32'(k << 8));
      c = rnd();
      running_counter_i <= c;
      pulse(k == 1 ? 4'h4 : (k == 2 ? 4'h8 : 4'h0), k == 3, 1'b0);
      rd(8'h3C, c);
      rd(8'h40, v[3]);
    end
    wr(8'h48, 32'hFFFF_FFFF);
    rd(8'h48, 32'h1F1F);
    wr(8'h48, 32'h0100);
    d0 = rnd();
    d1 = rnd();
    wr(8'h4C, d0);
    wr(8'h4C, d1);
    rd(8'h4C, {16'h0, d0[15:0]});
    rd(8'h4C, {16'h0, d1[15:0]});
    rd(8'h4C, {16'h0, d0[15:0]});
    wr(8'h48, 32'h010D);
    rd(8'h4C, {16'h0, v[0][15:0]});
    rd(8'h4C, {16'h0, w[15:0]});
    for (int k = 0; k < 4; k++)
    begin
      r = rnd();
      wr(8'h50, (r & 32'hFFFF_F3FF) | 32'(k << 10));
      src <= r[3:0];
      settle;
      chk_trigger(internal_trigger_one_o, r[k]);
      rd(8'h50, 32'(k << 10));
    end
    wr(8'h48, 32'h1100);
    for (int k = 0; k < 18; k++) wr(8'h4C, 32'h0000_A500 | 32'(k));
    rd(8'h4C, 32'h0000_A500);
    settle;
    complete_run;
  end
endmodule // timer_ccr_dma_burst_bench

// file: dv/timer_ccr_dma_burst_chk.sv
// Checker for the capture/compare register block, bound to its top module.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/10ps
module timer_ccr_dma_burst_chk (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_i,
  // Register port.
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  // Forwarded burst side.
  input wire logic [7:0] fwd_addr_o,
  input wire logic [15:0] fwd_wdata_o,
  input wire logic fwd_wr_o,
  input wire logic fwd_rd_o,
  input wire logic [4:0] burst_index_o,
  // Trigger sources and result.
  input wire logic other_timer_trigger_out_i,
  input wire logic ptp_trigger_i,
  input wire logic usb_fs_sof_i,
  input wire logic usb_hs_sof_i,
  input wire logic internal_trigger_one_o
);
  // ************************************************************
  // Shadow of the burst and remap fields.
  // ************************************************************
  logic [4:0] len_r;
  logic [4:0] base_r;
  logic [1:0] remap_r;
  logic run_r;
  wire win_w = (rd_i || wr_i) && addr_i == 8'h4C;
  wire [3:0] src_w = {usb_hs_sof_i, usb_fs_sof_i, ptp_trigger_i, other_timer_trigger_out_i};
  wire sel_w = src_w[remap_r];

  // The shadow follows direct writes only; run_r hides the first edge after reset.
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      len_r <= 5'h00;
      base_r <= 5'h00;
      remap_r <= 2'h0;
      run_r <= 1'b0;
    end
    else
    begin
      run_r <= 1'b1;
      if (wr_i && addr_i == 8'h48)
      begin
        len_r <= wdata_i[12:8];
        base_r <= wdata_i[4:0];
      end
      if (wr_i && addr_i == 8'h50)
        remap_r <= wdata_i[11:10];
    end
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  a_read_data_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data not zero outside a read answer");
  a_unmapped_zero: assert property (rd_i && addr_i > 8'h54 |=> rdata_o == 32'h0)
    else $error("unmapped read returned data");
  a_burst_reserved: assert property (rd_i && addr_i == 8'h48 |=> rdata_o[31:13] == 19'h0 && rdata_o[7:5] == 3'h0)
    else $error("reserved burst control bits not zero");
  a_trigger_select: assert property (run_r |-> internal_trigger_one_o == $past(sel_w))
    else $error("internal trigger one follows the wrong source");
  a_index_wrap: assert property (win_w && burst_index_o == len_r |=> burst_index_o == 5'h00)
    else $error("burst index did not wrap after the last transfer");
  a_index_step: assert property (win_w && burst_index_o != len_r |=> burst_index_o == $past(burst_index_o) + 5'h01)
    else $error("burst index did not advance");
  a_index_clear: assert property (wr_i && addr_i == 8'h48 |=> burst_index_o == 5'h00)
    else $error("burst index not cleared by burst control write");
  a_fwd_target: assert property (win_w |-> fwd_addr_o == {({1'b0, base_r} + {1'b0, burst_index_o}), 2'b00})
    else $error("window access aimed at the wrong register");
  a_fwd_window_only: assert property ((fwd_rd_o || fwd_wr_o) |-> win_w && fwd_addr_o <= 8'h30 && fwd_wr_o == wr_i)
    else $error("forwarded access without a window access");
endmodule // timer_ccr_dma_burst_chk

bind timer_ccr_dma_burst timer_ccr_dma_burst_chk u_chk (.mclk_i, .rst_i, .addr_i, .wdata_i,
  .wr_i, .rd_i, .rdata_o, .fwd_addr_o, .fwd_wdata_o, .fwd_wr_o, .fwd_rd_o, .burst_index_o,
  .other_timer_trigger_out_i, .ptp_trigger_i, .usb_fs_sof_i, .usb_hs_sof_i,
  .internal_trigger_one_o);

// file: dv/timer_regs_model.sv
// Model of the timer's other registers at offsets 0x00 to 0x30, reached by forwarding.
// Assumes forwarded strobes are single cycles and the read is answered in the same cycle.
`timescale 1ns/10ps
module timer_regs_model (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_i,
  // Forwarded access.
  input wire logic [7:0] fwd_addr_o,
  input wire logic [15:0] fwd_wdata_o,
  input wire logic fwd_wr_o,
  input wire logic fwd_rd_o,
  output logic [15:0] fwd_rdata_i
);
  logic [15:0] regs_r [0:12];
  logic [15:0] junk_r;
  wire [3:0] idx_w = fwd_addr_o[5:2];

  // Outside a read the data lines churn, so a stale value never looks valid.
  always_ff @(posedge mclk_i)
  begin
    junk_r <= rst_i ? 16'hA5A5 : ~junk_r;
    if (rst_i)
      for (int i = 0; i < 13; i++) regs_r[i] <= 16'h0000;
    else if (fwd_wr_o)
      regs_r[idx_w] <= fwd_wdata_o;
  end
  assign fwd_rdata_i = fwd_rd_o ? regs_r[idx_w] : junk_r;
endmodule // timer_regs_model
